// ==== rtl/blend_mixer.sv ====
// Summary of operation
// - non-match at minimum gives pure graphics
// - non-match at maximum gives pure video
// - proportional 256-step blend, interlace and overlay on
// - both maximum all video, both minimum all graphics
// - ramp moves ratio from start to end
// - match ramp alters only matching pixels
// - non-match ramp alters only non-matching pixels
// - ramp starts at programmed start level
// - ramp ends holding programmed end level
// - equal start and end ramp still runs
// - duration counted in fields, one step per field
// - zero field count: ramp not executed
// - trigger starts the ramp at once
// - one trigger may launch both ramps
// - blending only at 16 or 24 bit depth
// - overlay toggles video in every pixel
// - matching static level resets to minimum
`timescale 1ns/100ps
`default_nettype none
`include "blend_cfg.svh"
module blend_mixer #(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [23:0] gfx_pix,
	input wire logic [23:0] vid_pix,
	input wire logic pix_valid,
	output logic pix_ready,
	input wire logic vsync,
	output logic [23:0] out_pix,
	output logic out_valid,
	input wire logic out_ready
);
	// all state of the block outside the pixel fifo
	typedef struct packed {
		logic [3:0] ctrl;
		logic [23:0] match;
		logic [7:0] lvl_m;
		logic [7:0] lvl_n;
		logic [7:0] start_m;
		logic [7:0] end_m;
		logic [15:0] fields_m;
		logic [7:0] start_n;
		logic [7:0] end_n;
		logic [15:0] fields_n;
		blend_pkg::ramp_s ramp_m;
		blend_pkg::ramp_s ramp_n;
		logic [31:0] rdata;
		logic vs_meta;
		logic vs_sync;
		logic vs_last;
		logic [23:0] pix;
		logic pix_full;
	} state_s;
	state_s cur;
	state_s next_cur;
	blend_pkg::pix_s fifo_out;
	logic fifo_valid;
	logic fifo_ready;
	logic field_tick;
	logic blend_on;
	logic is_match;
	logic [7:0] lvl_sel;
	// pixel fifo in front of the mixer
	blend_fifo #(.WIDTH(48), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.rst(rst),
		.in_data({gfx_pix, vid_pix}),
		.in_valid(pix_valid),
		.in_ready(pix_ready),
		.out_data(fifo_out),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready)
	);
	// one channel blend: (g*(255-a) + v*a) / 255, a of 256 steps
	function automatic logic [7:0] mix8(input logic [7:0] g,
		input logic [7:0] v, input logic [7:0] a);
		logic [16:0] s;
		s = 17'(g) * 17'(8'hff - a) + 17'(v) * 17'(a);
		mix8 = 8'(s / 17'd255);
	endfunction
	// linear ramp level after step k of n
	function automatic logic [7:0] interp(input logic [7:0] s,
		input logic [7:0] e, input logic [15:0] k, input logic [15:0] n);
		logic signed [25:0] d;
		d = 26'(signed'({1'b0, e}) - signed'({1'b0, s}));
		d = d * signed'({10'h000, k}) / signed'({10'h000, n});
		interp = 8'(26'(signed'({1'b0, s})) + d);
	endfunction
	// ramp advance on trigger and at each field boundary
	function automatic blend_pkg::ramp_s ramp_step(
		input blend_pkg::ramp_s r, input logic trig, input logic tick,
		input logic [7:0] s, input logic [7:0] e, input logic [15:0] n);
		blend_pkg::ramp_s o;
		o = r;
		if (trig && n != 16'h0000) begin
			o.state = blend_pkg::RAMP_RUN;
			o.level = s;
			o.step = 16'h0000;
		end else if (r.state == blend_pkg::RAMP_RUN && tick) begin
			o.step = r.step + 16'h0001;
			o.level = interp(s, e, o.step, n);
			if (o.step == n)
				o.state = blend_pkg::RAMP_IDLE;
		end
		return o;
	endfunction
	assign field_tick = cur.vs_sync && !cur.vs_last;
	assign blend_on = cur.ctrl[`CTRL_INTERLACE] && cur.ctrl[`CTRL_OVERLAY]
		&& (cur.ctrl[`CTRL_DEPTH_HI:`CTRL_DEPTH_LO] == `DEPTH_16
		|| cur.ctrl[`CTRL_DEPTH_HI:`CTRL_DEPTH_LO] == `DEPTH_24);
	assign is_match = fifo_out.gfx == cur.match;
	assign fifo_ready = !cur.pix_full || out_ready;
	// next-state logic
	always_comb begin
		next_cur = cur;
		next_cur.vs_meta = vsync;
		next_cur.vs_sync = cur.vs_meta;
		next_cur.vs_last = cur.vs_sync;
		// register writes
		if (wr) begin
			case (addr)
				`OFS_CTRL: next_cur.ctrl = wdata[3:0];
				`OFS_MATCH: next_cur.match = wdata[23:0];
				`OFS_LVL: begin
					next_cur.lvl_m = wdata[7:0];
					next_cur.lvl_n = wdata[15:8];
				end
				`OFS_RAMP_M: begin
					next_cur.start_m = wdata[7:0];
					next_cur.end_m = wdata[15:8];
					next_cur.fields_m = wdata[31:16];
				end
				`OFS_RAMP_N: begin
					next_cur.start_n = wdata[7:0];
					next_cur.end_n = wdata[15:8];
					next_cur.fields_n = wdata[31:16];
				end
				default: ;
			endcase
		end
		// ramps: one trigger write may start both at once
		next_cur.ramp_m = ramp_step(cur.ramp_m,
			wr && addr == `OFS_TRIG && wdata[`TRIG_MATCH], field_tick,
			cur.start_m, cur.end_m, cur.fields_m);
		next_cur.ramp_n = ramp_step(cur.ramp_n,
			wr && addr == `OFS_TRIG && wdata[`TRIG_NONMATCH], field_tick,
			cur.start_n, cur.end_n, cur.fields_n);
		// a finished ramp leaves its end level as the static level
		if (cur.ramp_m.state == blend_pkg::RAMP_RUN
			&& next_cur.ramp_m.state == blend_pkg::RAMP_IDLE)
			next_cur.lvl_m = next_cur.ramp_m.level;
		if (cur.ramp_n.state == blend_pkg::RAMP_RUN
			&& next_cur.ramp_n.state == blend_pkg::RAMP_IDLE)
			next_cur.lvl_n = next_cur.ramp_n.level;
		// read data, one cycle after strobe
		next_cur.rdata = 32'h0000_0000;
		if (rd) begin
			case (addr)
				`OFS_CTRL: next_cur.rdata = {28'h0, cur.ctrl};
				`OFS_MATCH: next_cur.rdata = {8'h00, cur.match};
				`OFS_LVL: next_cur.rdata = {16'h0, cur.lvl_n, cur.lvl_m};
				`OFS_RAMP_M: next_cur.rdata = {cur.fields_m, cur.end_m,
					cur.start_m};
				`OFS_RAMP_N: next_cur.rdata = {cur.fields_n, cur.end_n,
					cur.start_n};
				`OFS_STATUS: next_cur.rdata = {cur.ramp_n.level,
					cur.ramp_m.level, 14'h0, cur.ramp_n.state == 
					blend_pkg::RAMP_RUN, cur.ramp_m.state ==
					blend_pkg::RAMP_RUN};
				default: next_cur.rdata = 32'h0000_0000;
			endcase
		end
		// pixel output stage
		if (cur.pix_full && out_ready)
			next_cur.pix_full = 1'b0;
		if (fifo_valid && fifo_ready) begin
			next_cur.pix_full = 1'b1;
			next_cur.pix = fifo_out.gfx;
			if (blend_on) begin
				// per channel blend
				for (int i = 0; i < 3; i++)
					next_cur.pix[i*8 +: 8] = mix8(fifo_out.gfx[i*8 +: 8],
						fifo_out.vid[i*8 +: 8], lvl_sel);
			end
		end
	end
	// level picked per pixel class; each ramp owns only its class
	always_comb begin
		if (is_match)
			lvl_sel = cur.ramp_m.state == blend_pkg::RAMP_RUN
				? cur.ramp_m.level : cur.lvl_m;
		else
			lvl_sel = cur.ramp_n.state == blend_pkg::RAMP_RUN
				? cur.ramp_n.level : cur.lvl_n;
	end
	// state register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cur <= '0;
			cur.lvl_m <= `LVL_RESET;
			cur.lvl_n <= `LVL_RESET;
			cur.match <= `MATCH_RESET;
		end else begin
			cur <= next_cur;
		end
	end
	assign rdata = cur.rdata;
	assign out_pix = cur.pix;
	assign out_valid = cur.pix_full;
	// checks, all on the pixel clock and quiet during reset
	default clocking chk_clk @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// minimum level passes graphics through untouched
	a_min_gives_gfx: assert property (
		fifo_valid && fifo_ready && lvl_sel == 8'h00
		|=> out_pix == $past(fifo_out.gfx))
		else $error("minimum level did not give graphics");
	// maximum level with blending on passes video through
	a_max_gives_vid: assert property (
		fifo_valid && fifo_ready && blend_on && lvl_sel == 8'hff
		|=> out_pix == $past(fifo_out.vid))
		else $error("maximum level did not give video");
	// both static levels at maximum: every pixel is video
	a_both_max: assert property (
		fifo_valid && fifo_ready && blend_on && cur.lvl_m == 8'hff
		&& cur.lvl_n == 8'hff
		&& cur.ramp_m.state == blend_pkg::RAMP_IDLE
		&& cur.ramp_n.state == blend_pkg::RAMP_IDLE
		|=> out_pix == $past(fifo_out.vid))
		else $error("both maximum did not give video");
	// both static levels at minimum: every pixel is graphics
	a_both_min: assert property (
		fifo_valid && fifo_ready && cur.lvl_m == 8'h00
		&& cur.lvl_n == 8'h00
		&& cur.ramp_m.state == blend_pkg::RAMP_IDLE
		&& cur.ramp_n.state == blend_pkg::RAMP_IDLE
		|=> out_pix == $past(fifo_out.gfx))
		else $error("both minimum did not give graphics");
	// palette depths and other gated modes show graphics only
	a_depth_gate: assert property (
		fifo_valid && fifo_ready && !blend_on
		|=> out_pix == $past(fifo_out.gfx))
		else $error("blend active outside allowed depth");
	// no blend while the output is not interlaced
	a_interlace_off: assert property (
		fifo_valid && fifo_ready && !cur.ctrl[`CTRL_INTERLACE]
		|=> out_pix == $past(fifo_out.gfx))
		else $error("blend active without interlace");
	// overlay off removes video from the picture
	a_overlay_off: assert property (
		fifo_valid && fifo_ready && !cur.ctrl[`CTRL_OVERLAY]
		|=> out_pix == $past(fifo_out.gfx))
		else $error("blend active with overlay off");
	// zero field count never starts the match ramp
	a_zero_count: assert property (
		wr && addr == `OFS_TRIG && wdata[`TRIG_MATCH]
		&& cur.fields_m == 16'h0000
		&& cur.ramp_m.state == blend_pkg::RAMP_IDLE
		|=> cur.ramp_m.state == blend_pkg::RAMP_IDLE)
		else $error("zero count ramp started");
	// zero field count never starts the non-match ramp
	a_zero_count_n: assert property (
		wr && addr == `OFS_TRIG && wdata[`TRIG_NONMATCH]
		&& cur.fields_n == 16'h0000
		&& cur.ramp_n.state == blend_pkg::RAMP_IDLE
		|=> cur.ramp_n.state == blend_pkg::RAMP_IDLE)
		else $error("zero count non-match ramp started");
	// a trigger starts the non-match ramp on the next edge
	a_trig_start: assert property (
		wr && addr == `OFS_TRIG && wdata[`TRIG_NONMATCH]
		&& cur.fields_n != 16'h0000
		|=> cur.ramp_n.state == blend_pkg::RAMP_RUN
		&& cur.ramp_n.level == $past(cur.start_n))
		else $error("ramp did not start at start level");
	// a trigger starts the match ramp at its start level
	a_trig_start_m: assert property (
		wr && addr == `OFS_TRIG && wdata[`TRIG_MATCH]
		&& cur.fields_m != 16'h0000
		|=> cur.ramp_m.state == blend_pkg::RAMP_RUN
		&& cur.ramp_m.level == $past(cur.start_m))
		else $error("match ramp did not start at start level");
	// one trigger write launches both ramps together
	a_both_trig: assert property (
		wr && addr == `OFS_TRIG && wdata[`TRIG_MATCH]
		&& wdata[`TRIG_NONMATCH] && cur.fields_m != 16'h0000
		&& cur.fields_n != 16'h0000
		|=> cur.ramp_m.state == blend_pkg::RAMP_RUN
		&& cur.ramp_n.state == blend_pkg::RAMP_RUN)
		else $error("single trigger did not start both ramps");
	// the match ramp only steps at a field boundary
	a_ramp_hold: assert property (
		cur.ramp_m.state == blend_pkg::RAMP_RUN && !field_tick && !wr
		|=> $stable(cur.ramp_m.step))
		else $error("ramp stepped without field boundary");
	// the non-match ramp only steps at a field boundary
	a_ramp_hold_n: assert property (
		cur.ramp_n.state == blend_pkg::RAMP_RUN && !field_tick && !wr
		|=> $stable(cur.ramp_n.step))
		else $error("non-match ramp stepped off boundary");
	// each field boundary advances a running match ramp by one step
	a_tick_step: assert property (
		cur.ramp_m.state == blend_pkg::RAMP_RUN && field_tick && !wr
		|=> cur.ramp_m.step == $past(cur.ramp_m.step) + 16'h0001)
		else $error("ramp did not step at field boundary");
	// a finished match ramp holds its end level
	a_ramp_end: assert property (
		$fell(cur.ramp_m.state == blend_pkg::RAMP_RUN) && !$past(wr)
		|-> cur.lvl_m == cur.end_m && cur.ramp_m.level == cur.end_m)
		else $error("ramp did not end at end level");
	// a finished non-match ramp holds its end level
	a_ramp_end_n: assert property (
		$fell(cur.ramp_n.state == blend_pkg::RAMP_RUN) && !$past(wr)
		|-> cur.lvl_n == cur.end_n && cur.ramp_n.level == cur.end_n)
		else $error("non-match ramp did not end at end level");
	// equal start and end levels leave the mix where it was
	a_equal_levels: assert property (
		cur.ramp_m.state == blend_pkg::RAMP_RUN && field_tick && !wr
		&& cur.start_m == cur.end_m
		|=> cur.ramp_m.level == $past(cur.end_m))
		else $error("equal level ramp changed the mix");
	// the match ramp never reaches non-matching pixels
	a_class_match: assert property (
		fifo_valid && !is_match
		&& cur.ramp_m.state == blend_pkg::RAMP_RUN
		|-> lvl_sel == (cur.ramp_n.state == blend_pkg::RAMP_RUN
		? cur.ramp_n.level : cur.lvl_n))
		else $error("match ramp reached a non-matching pixel");
	// the non-match ramp never reaches matching pixels
	a_class_nonmatch: assert property (
		fifo_valid && is_match
		&& cur.ramp_n.state == blend_pkg::RAMP_RUN
		|-> lvl_sel == (cur.ramp_m.state == blend_pkg::RAMP_RUN
		? cur.ramp_m.level : cur.lvl_m))
		else $error("non-match ramp reached a matching pixel");
	// an output pixel stands until the sink takes it
	a_out_hold: assert property (
		out_valid && !out_ready
		|=> out_valid && $stable(out_pix))
		else $error("output pixel dropped before taken");
	// matching class starts from pure graphics
	a_match_reset: assert property (
		$fell(rst) |-> cur.lvl_m == 8'h00)
		else $error("match level not minimum after reset");
endmodule
`default_nettype wire

// ==== shared/blend_cfg.svh ====
`ifndef BLEND_CFG_SVH
`define BLEND_CFG_SVH
// register offsets
`define OFS_CTRL 4'h0
`define OFS_MATCH 4'h1
`define OFS_LVL 4'h2
`define OFS_RAMP_M 4'h3
`define OFS_RAMP_N 4'h4
`define OFS_TRIG 4'h5
`define OFS_STATUS 4'h6
// control fields
`define CTRL_INTERLACE 0
`define CTRL_OVERLAY 1
`define CTRL_DEPTH_LO 2
`define CTRL_DEPTH_HI 3
// depth codes that allow blending
`define DEPTH_16 2'h2
`define DEPTH_24 2'h3
// reset values
`define LVL_RESET 8'h00
`define MATCH_RESET 24'h000000
// trigger bits
`define TRIG_MATCH 0
`define TRIG_NONMATCH 1
`endif

// ==== shared/blend_pkg.sv ====
package blend_pkg;
	typedef struct packed {
		logic [23:0] gfx;
		logic [23:0] vid;
	} pix_s;
	typedef enum logic [0:0] {
		RAMP_IDLE,
		RAMP_RUN
	} ramp_state_e;
	typedef struct packed {
		ramp_state_e state;
		logic [7:0] level;
		logic [15:0] step;
	} ramp_s;
endpackage

// ==== rtl/blend_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
// small synchronous fifo with valid/ready on both sides
module blend_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp;
	logic [AW:0] rp;
	logic [AW:0] cnt;
	assign cnt = wp - rp;
	assign in_ready = cnt != (AW+1)'(DEPTH);
	assign out_valid = cnt != '0;
	assign out_data = mem[rp[AW-1:0]];
	// pointer update; memory written on accepted push
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wp <= '0;
			rp <= '0;
		end else begin
			if (in_valid && in_ready)
				wp <= wp + 1'b1;
			if (out_valid && out_ready)
				rp <= rp + 1'b1;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (in_valid && in_ready)
			mem[wp[AW-1:0]] <= in_data;
	end
endmodule
`default_nettype wire

// ==== tb/pix_source.sv ====
`timescale 1ns/100ps
`default_nettype none
// frame buffer and decoder stand-in: offers one pixel pair per send
module pix_source (
	input wire logic ref_clk,
	output logic [23:0] gfx_pix,
	output logic [23:0] vid_pix,
	output logic pix_valid,
	input wire logic pix_ready
);
	initial begin
		gfx_pix = 24'h0;
		vid_pix = 24'h0;
		pix_valid = 1'b0;
	end
	// hold the pair until taken, then scramble the idle lines
	task automatic send(input logic [23:0] g, input logic [23:0] v);
		int n;
		n = 0;
		@(posedge ref_clk);
		gfx_pix <= g;
		vid_pix <= v;
		pix_valid <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pix_ready !== 1'b1 && n < 200);
		pix_valid <= 1'b0;
		gfx_pix <= ~g;
		vid_pix <= ~v;
	endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "blend_cfg.svh"
module tb_top;
	localparam logic [23:0] KEY = 24'h12ab34;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic vsync = 1'b0;
	logic out_ready = 1'b0;
	logic stall = 1'b0;
	logic [31:0] rdata;
	logic [23:0] gfx_pix, vid_pix, out_pix;
	logic pix_valid, pix_ready, out_valid, en;
	logic [31:0] rs = 32'd63340;
	logic [31:0] rr = 32'd63340;
	logic [23:0] expq[$];
	logic [7:0] am, an;
	logic [7:0] lm[5] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h80};
	logic [7:0] ln[5] = '{8'h00, 8'hff, 8'hff, 8'h00, 8'h3c};
	logic [3:0] cv[4] = '{4'hb, 4'hd, 4'he, 4'h7};
	int n_fail = 0;
	int checked = 0;
	int cyc = 0;
	always #20 ref_clk = ~ref_clk;
	blend_mixer blend_mixer_i (.ref_clk(ref_clk), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .gfx_pix(gfx_pix),
		.vid_pix(vid_pix), .pix_valid(pix_valid), .pix_ready(pix_ready),
		.vsync(vsync), .out_pix(out_pix), .out_valid(out_valid),
		.out_ready(out_ready));
	pix_source pix_source_i (.ref_clk(ref_clk), .gfx_pix(gfx_pix),
		.vid_pix(vid_pix), .pix_valid(pix_valid), .pix_ready(pix_ready));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	// per channel (g*(255-a)+v*a)/255
	function automatic logic [23:0] mix(input logic [23:0] g,
		input logic [23:0] v, input logic [7:0] a);
		logic [23:0] r;
		for (int c = 0; c < 24; c += 8)
			r[c+:8] = 8'((16'(g[c+:8]) * (16'hff - 16'(a))
				+ 16'(v[c+:8]) * 16'(a)) / 16'hff);
		return r;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// let queued pixels leave before anything that changes the mix
	task automatic drain;
		for (int n = 0; n < 500 && expq.size() > 0; n++)
			@(posedge ref_clk);
	endtask
	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		drain();
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 check(rdata, exp);
	endtask
	// one field boundary through the vsync synchroniser
	task automatic field;
		drain();
		@(posedge ref_clk);
		vsync <= 1'b1;
		repeat (4) @(posedge ref_clk);
		vsync <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask
	// non-matching pixels differ from the key in bit 0
	task automatic pix(input logic m);
		logic [23:0] g;
		rs = xs(rs);
		g = m ? KEY : {rs[23:1], ~KEY[0]};
		rs = xs(rs);
		expq.push_back(!en ? g : mix(g, rs[23:0], m ? am : an));
		pix_source_i.send(g, rs[23:0]);
	endtask
	// sink with random stalls, scoreboard and hang guard
	always @(posedge ref_clk) begin
		cyc++;
		rr = xs(rr);
		out_ready <= !stall && rr[1:0] != 2'h0;
		if (!rst && out_valid === 1'b1 && out_ready === 1'b1)
			check(32'(out_pix),
				expq.size() ? 32'(expq.pop_front()) : 32'hx);
		if (cyc == 20000) begin
			n_fail++;
			print_verdict();
		end
	end
	initial begin
		am = 8'h00;
		an = 8'h00;
		en = 1'b0;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		rreg(`OFS_LVL, 32'h0);
		rreg(4'hf, 32'h0);
		wreg(`OFS_MATCH, 32'(KEY));
		wreg(`OFS_CTRL, 32'hf);
		en = 1'b1;
		// static levels of both classes
		for (int i = 0; i < 5; i++) begin
			am = lm[i];
			an = ln[i];
			wreg(`OFS_LVL, {16'h0, an, am});
			pix(1'b1);
			pix(1'b0);
		end
		// depth, overlay and interlace gating
		for (int i = 0; i < 4; i++) begin
			wreg(`OFS_CTRL, 32'(cv[i]));
			en = (i == 0);
			pix(1'b1);
			pix(1'b0);
		end
		wreg(`OFS_CTRL, 32'hf);
		en = 1'b1;
		$display("test static done");
		// match ramp 20 to ff over two fields; status shows ramp levels
		am = 8'h00;
		an = 8'h40;
		wreg(`OFS_LVL, 32'h4000);
		wreg(`OFS_RAMP_M, 32'h0002ff20);
		wreg(`OFS_TRIG, 32'h1);
		rreg(`OFS_STATUS, 32'h00200001);
		am = 8'h20;
		pix(1'b1);
		pix(1'b0);
		field();
		rreg(`OFS_STATUS, 32'h008f0001);
		am = 8'h8f;
		pix(1'b1);
		field();
		rreg(`OFS_STATUS, 32'h00ff0000);
		rreg(`OFS_LVL, 32'h40ff);
		am = 8'hff;
		pix(1'b1);
		// zero count, equal levels, both at once
		wreg(`OFS_RAMP_N, 32'h0000ff80);
		wreg(`OFS_TRIG, 32'h2);
		rreg(`OFS_STATUS, 32'h00ff0000);
		wreg(`OFS_RAMP_M, 32'h00013333);
		wreg(`OFS_RAMP_N, 32'h00010090);
		wreg(`OFS_TRIG, 32'h3);
		rreg(`OFS_STATUS, 32'h90330003);
		am = 8'h33;
		an = 8'h90;
		pix(1'b1);
		pix(1'b0);
		field();
		rreg(`OFS_STATUS, 32'h00330000);
		rreg(`OFS_LVL, 32'h0033);
		// the non-match ramp left its end level behind
		an = 8'h00;
		$display("test ramp done");
		// fill the buffer while the sink stalls
		drain();
		stall = 1'b1;
		repeat (2) @(posedge ref_clk);
		repeat (9) pix(1'b0);
		@(posedge ref_clk);
		#1 check(32'(pix_ready), 32'h0);
		stall = 1'b0;
		drain();
		check(32'(expq.size()), 32'h0);
		$display("test fill done");
		print_verdict();
	end
endmodule
`default_nettype wire
